// *** twr_pkg.sv ***
// Purpose: Shared constants and types for the two-wire register port
// Assumes: 8-bit registers, 26 locations, open-drain data line
// Notes:   Field positions refer to the two mode registers
package twr_pkg;

  // ----------------------------------------
  // Register space
  // ----------------------------------------
  localparam int          NUM_REGS        = 26;
  localparam int          REG_W           = 8;
  localparam int          TGT_W           = 6;
  localparam logic [7:0]  VIDEO_CFG_A_OFS = 8'h00;
  localparam logic [7:0]  VIDEO_CFG_B_OFS = 8'h01;
  localparam logic [7:0]  REG_RST         = 8'h00;

  // ----------------------------------------
  // Field positions, video_config_a
  // ----------------------------------------
  localparam int TV_STD_LSB   = 0;
  localparam int TV_STD_W     = 2;
  localparam int LUMA_LSB     = 2;
  localparam int CHROMA_LSB   = 5;
  localparam int FILT_W       = 3;

  // ----------------------------------------
  // Field positions, video_config_b
  // ----------------------------------------
  localparam int INTERLACE_BIT = 0;
  localparam int CAPTION_LSB   = 1;
  localparam int CAPTION_W     = 2;
  localparam int PD_LO_BIT     = 3;
  localparam int RESV_ONE_BIT  = 4;
  localparam int PD_HI_LSB     = 5;
  localparam int PD_HI_W       = 2;
  localparam int COLOR_BAR_BIT = 7;

  // ----------------------------------------
  // Serial framing
  // ----------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic       DIR_READ      = 1'b1;
  localparam logic [6:0] SLAVE_ADDR_HI = 7'h2a;  // Arbitrary neutral value

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_RD_NEXT
  } twr_state_t;

endpackage

// *** twr_sync.sv ***
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to core_clk_i
// Notes:   Only the second stage leaves the module
`timescale 1ns/1ps
`default_nettype none
module twr_sync #(
  parameter int W = 2
) (
  input  wire logic         core_clk_i,  // Core clock
  input  wire logic         srst_i,      // Sync reset, active high
  input  wire logic [W-1:0] async_i,     // Raw pin levels
  output logic      [W-1:0] sync_o       // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } twr_sync_t;

  twr_sync_t s_r;
  twr_sync_t s_nxt;

  if (W < 1) begin : g_chk
    $error("twr_sync: W must be at least 1");
  end

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ff1 = async_i;
    s_nxt.ff2 = s_r.ff1;
  end

  // Idle bus level is high
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_o = s_r.ff2;
endmodule // twr_sync
`default_nettype wire

// *** twr_regfile.sv ***
// Purpose: Register storage for the two-wire register port
// Assumes: One write port, one combinational read port
// Notes:   Mode register bits leave straight from storage
`timescale 1ns/1ps
`default_nettype none
module twr_regfile
  import twr_pkg::*;
#(
  parameter int N = NUM_REGS
) (
  input  wire logic       core_clk_i,  // Core clock
  input  wire logic       srst_i,      // Sync reset, active high
  input  wire logic       wr_en_i,     // Write strobe
  input  wire logic [7:0] wr_addr_i,   // Write location
  input  wire logic [7:0] wr_data_i,   // Write data
  input  wire logic [7:0] rd_addr_i,   // Read location
  output logic      [7:0] rd_data_o,   // Read data
  output logic      [7:0] cfg_a_o,     // video_config_a contents
  output logic      [7:0] cfg_b_o      // video_config_b contents
);
  typedef struct packed {
    logic [N-1:0][REG_W-1:0] mem;
  } twr_rf_t;

  twr_rf_t s_r;
  twr_rf_t s_nxt;

  if (N < 2 || N > 64) begin : g_chk
    $error("twr_regfile: N must lie in 2..64");
  end

  for (genvar i = 0; i < N; i++) begin : g_wr
    always_comb begin
      s_nxt.mem[i] = s_r.mem[i];
      if (wr_en_i && wr_addr_i == 8'(i)) begin
        s_nxt.mem[i] = wr_data_i;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_r <= {N{REG_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    rd_data_o = REG_RST;
    for (int i = 0; i < N; i++) begin
      if (rd_addr_i == 8'(i)) begin
        rd_data_o = s_r.mem[i];
      end
    end
  end

  assign cfg_a_o = s_r.mem[VIDEO_CFG_A_OFS[5:0]];
  assign cfg_b_o = s_r.mem[VIDEO_CFG_B_OFS[5:0]];
endmodule // twr_regfile
`default_nettype wire

// *** twr_port.sv ***
// Purpose: Two-wire serial slave giving a host access to mode registers
// Assumes: Serial clock is far slower than core_clk_i
// Notes:   Data line is open drain; pin levels pass two flip-flops
`timescale 1ns/1ps
`default_nettype none
module twr_port
  import twr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_HI,  // Arbitrary value
  parameter int         REGS       = NUM_REGS
) (
  input  wire logic       core_clk_i,                // Core clock
  input  wire logic       srst_i,                    // Sync reset
  input  wire logic       serial_clock_line_i,       // Bus clock pin
  input  wire logic       serial_data_line_i,        // Bus data pin in
  output logic            serial_data_line_o,        // Bus data out
  output logic            serial_data_line_oe_n_o,   // Low drives
  input  wire logic       address_select_pin_i,      // Address select
  output logic [1:0]      tv_standard_o,             // Output standard
  output logic [2:0]      luma_filter_o,             // Luma filter
  output logic [2:0]      chroma_filter_o,           // Chroma filter
  output logic            interlace_select_o,        // Interlace mode
  output logic [1:0]      caption_field_select_o,    // Caption fields
  output logic [1:0]      converter_powerdown_hi_o,  // Converter off
  output logic            converter_powerdown_lo_o,  // Converter off
  output logic            reserved_one_bit_o,        // Reserved bit
  output logic            color_bar_enable_o,        // Color bars on
  output logic            master_timing_force_o,     // Master timing
  output logic            bus_busy_o,                // Between start/stop
  output logic            selected_o                 // Addressed by host
);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (REGS < 2 || REGS > 64) begin : g_chk
    $error("twr_port: REGS must lie in 2..64");
  end

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic loc_valid(input logic [7:0] loc);
    return loc < 8'(REGS);
  endfunction

  function automatic logic [7:0] loc_sat(input logic [7:0] loc);
    return loc_valid(loc) ? loc : 8'(REGS - 1);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    twr_state_t st;
    logic [3:0] cnt;
    logic [7:0] shf;
    logic [7:0] ptr;
    logic       rd;
    logic       scl_q;
    logic       sda_q;
    logic       oe_n;
    logic       sd_o;
    logic       busy;
    logic       sel;
    logic       asel;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } twr_port_t;

  // ----------------------------------------
  // Registered state and internal nets
  // ----------------------------------------
  twr_port_t  s_r;
  twr_port_t  s_nxt;
  logic [2:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       asel_s;
  logic [7:0] rd_data;
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic [6:0] my_addr;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  twr_sync #(
    .W (3)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .async_i    ({address_select_pin_i, serial_clock_line_i,
                  serial_data_line_i}),
    .sync_o     (pins_s)
  );

  // ----------------------------------------
  // Synchronised pin views
  // ----------------------------------------
  // Only second stage levels are used here
  assign sda_s  = pins_s[0];
  assign scl_s  = pins_s[1];
  assign asel_s = pins_s[2];

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  twr_regfile #(
    .N (REGS)
  ) u_regs (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .wr_en_i    (s_r.wr_en),
    .wr_addr_i  (s_r.wr_addr),
    .wr_data_i  (s_r.wr_data),
    .rd_addr_i  (loc_sat(s_r.ptr)),
    .rd_data_o  (rd_data),
    .cfg_a_o    (cfg_a),
    .cfg_b_o    (cfg_b)
  );

  // ----------------------------------------
  // Bus condition detection
  // ----------------------------------------
  // Conditions only count while clock stays high
  assign scl_rise  = scl_s & ~s_r.scl_q;
  assign scl_fall  = ~scl_s & s_r.scl_q;
  assign start_det = scl_s & s_r.scl_q & s_r.sda_q & ~sda_s;
  assign stop_det  = scl_s & s_r.scl_q & ~s_r.sda_q & sda_s;
  assign my_addr   = {SLAVE_ADDR[6:1], s_r.asel};

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.scl_q = scl_s;
    s_nxt.sda_q = sda_s;
    s_nxt.asel  = asel_s;
    s_nxt.wr_en = 1'b0;
    s_nxt.sd_o  = 1'b0;
    // Bus conditions override byte progress
    if (start_det) begin
      // Repeated start also lands here
      s_nxt.st   = ST_ADDR;
      s_nxt.cnt  = 4'h0;
      s_nxt.oe_n = 1'b1;
      s_nxt.busy = 1'b1;
      s_nxt.sel  = 1'b0;
    end else if (stop_det) begin
      s_nxt.st   = ST_IDLE;
      s_nxt.oe_n = 1'b1;
      s_nxt.busy = 1'b0;
      s_nxt.sel  = 1'b0;
    end else begin
      case (s_r.st)
        // Wait for start, line released
        ST_IDLE: begin
          s_nxt.oe_n = 1'b1;
          s_nxt.sel  = 1'b0;
        end

        // Shift one byte, act on eighth fall
        ST_ADDR, ST_PTR, ST_WR: begin
          if (scl_rise) begin
            s_nxt.shf = {s_r.shf[6:0], sda_s};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall && s_r.cnt == BITS_PER_BYTE) begin
            s_nxt.cnt = 4'h0;
            if (s_r.st == ST_ADDR) begin
              if (s_r.shf[7:1] == my_addr) begin
                s_nxt.oe_n = 1'b0;
                s_nxt.rd   = (s_r.shf[0] == DIR_READ);
                s_nxt.sel  = 1'b1;
                s_nxt.st   = ST_ADDR_ACK;
              end else begin
                s_nxt.st   = ST_IDLE;
              end
            end else if (s_r.st == ST_PTR) begin
              if (loc_valid(s_r.shf)) begin
                s_nxt.ptr  = s_r.shf;
                s_nxt.oe_n = 1'b0;
                s_nxt.st   = ST_PTR_ACK;
              end else begin
                s_nxt.st   = ST_IDLE;
              end
            end else begin
              if (loc_valid(s_r.ptr)) begin
                s_nxt.wr_en   = 1'b1;
                s_nxt.wr_addr = s_r.ptr;
                s_nxt.wr_data = s_r.shf;
                s_nxt.ptr     = s_r.ptr + 8'h01;
                s_nxt.oe_n    = 1'b0;
                s_nxt.st      = ST_WR_ACK;
              end else begin
                s_nxt.st      = ST_IDLE;
              end
            end
          end
        end

        // Hold ack through ninth clock
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (s_r.rd) begin
              s_nxt.shf  = rd_data;
              s_nxt.oe_n = rd_data[7];
              s_nxt.st   = ST_RD;
            end else begin
              s_nxt.oe_n = 1'b1;
              s_nxt.st   = ST_PTR;
            end
          end
        end

        // Release after ack, next byte follows
        ST_PTR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            s_nxt.oe_n = 1'b1;
            s_nxt.st   = ST_WR;
          end
        end

        // Send byte, one bit per clock fall
        ST_RD: begin
          if (scl_rise) begin
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_r.cnt == BITS_PER_BYTE) begin
              s_nxt.cnt  = 4'h0;
              s_nxt.oe_n = 1'b1;
              s_nxt.st   = ST_RD_ACK;
            end else begin
              // Released line reads as one
              s_nxt.shf  = {s_r.shf[6:0], 1'b0};
              s_nxt.oe_n = s_r.shf[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              s_nxt.st  = ST_IDLE;
            end else begin
              s_nxt.ptr = loc_sat(s_r.ptr + 8'h01);
              s_nxt.st  = ST_RD_NEXT;
            end
          end
        end

        // Load next byte on following fall
        ST_RD_NEXT: begin
          if (scl_fall) begin
            s_nxt.shf  = rd_data;
            s_nxt.oe_n = rd_data[7];
            s_nxt.st   = ST_RD;
          end
        end

        // Unknown state recovers to idle
        default: begin
          s_nxt.st   = ST_IDLE;
          s_nxt.oe_n = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Line history resets to idle high, no false edge
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_r       <= '0;
      s_r.st    <= ST_IDLE;
      s_r.oe_n  <= 1'b1;
      s_r.scl_q <= 1'b1;
      s_r.sda_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign serial_data_line_o      = s_r.sd_o;
  assign serial_data_line_oe_n_o = s_r.oe_n;
  assign bus_busy_o              = s_r.busy;
  assign selected_o              = s_r.sel;

  // ----------------------------------------
  // Mode register fields
  // ----------------------------------------
  assign tv_standard_o            = cfg_a[TV_STD_LSB +: TV_STD_W];
  assign luma_filter_o            = cfg_a[LUMA_LSB +: FILT_W];
  assign chroma_filter_o          = cfg_a[CHROMA_LSB +: FILT_W];
  assign interlace_select_o       = cfg_b[INTERLACE_BIT];
  assign caption_field_select_o   = cfg_b[CAPTION_LSB +: CAPTION_W];
  assign converter_powerdown_hi_o = cfg_b[PD_HI_LSB +: PD_HI_W];
  assign converter_powerdown_lo_o = cfg_b[PD_LO_BIT];
  assign reserved_one_bit_o       = cfg_b[RESV_ONE_BIT];
  assign color_bar_enable_o       = cfg_b[COLOR_BAR_BIT];
  assign master_timing_force_o    = cfg_b[COLOR_BAR_BIT];

endmodule // twr_port
`default_nettype wire

// *** twr_port_assertions.sv ***
// Purpose: Concurrent checks on the register port pins
// Assumes: Single core clock domain
// Notes:   Bound to twr_port below
`timescale 1ns/1ps
`default_nettype none
module twr_port_assertions (
  input wire logic       core_clk_i,               // Core clock
  input wire logic       srst_i,                   // Sync reset
  input wire logic       serial_clock_line_i,      // Bus clock
  input wire logic       serial_data_line_i,       // Bus data
  input wire logic       serial_data_line_o,       // Data out
  input wire logic       serial_data_line_oe_n_o,  // Low drives
  input wire logic [1:0] tv_standard_o,            // Standard
  input wire logic       color_bar_enable_o,       // Color bars
  input wire logic       master_timing_force_o,    // Master timing
  input wire logic       bus_busy_o,               // Busy
  input wire logic       selected_o                // Addressed
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_start;
    serial_clock_line_i && $fell(serial_data_line_i);
  endsequence
  sequence s_stop;
    serial_clock_line_i && $rose(serial_data_line_i);
  endsequence
  a_start_busy: assert property (s_start |-> ##[1:6] bus_busy_o)
    else $error("busy missing after start");
  a_stop_idle: assert property (s_stop |-> ##[1:6] !bus_busy_o)
    else $error("busy stuck after stop");
  a_stop_unselect: assert property ($fell(bus_busy_o) |-> ##[0:1] !selected_o)
    else $error("still selected after stop");
  a_idle_release: assert property (!bus_busy_o |-> serial_data_line_oe_n_o)
    else $error("data driven while idle");
  a_cfg_hold: assert property (!selected_o && !$past(selected_o)
    |-> $stable({tv_standard_o, color_bar_enable_o}))
    else $error("config changed unaddressed");
  a_drain_only: assert property (!serial_data_line_oe_n_o |-> !serial_data_line_o)
    else $error("data line driven high");
  a_drive_clk_low: assert property ($changed(serial_data_line_oe_n_o) |-> !serial_clock_line_i)
    else $error("data drive moved in clock high");
  a_drive_hold: assert property ($changed(serial_data_line_oe_n_o)
    |=> $stable(serial_data_line_oe_n_o)[*6])
    else $error("data drive not held");
  a_bar_master: assert property (master_timing_force_o == color_bar_enable_o)
    else $error("master timing not tied to bars");
endmodule // twr_port_assertions
bind twr_port twr_port_assertions u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
  .serial_clock_line_i(serial_clock_line_i), .serial_data_line_i(serial_data_line_i),
  .serial_data_line_o(serial_data_line_o), .serial_data_line_oe_n_o(serial_data_line_oe_n_o),
  .tv_standard_o(tv_standard_o), .color_bar_enable_o(color_bar_enable_o),
  .master_timing_force_o(master_timing_force_o), .bus_busy_o(bus_busy_o),
  .selected_o(selected_o));
`default_nettype wire

// *** twr_host_model.sv ***
// Purpose: Two-wire bus master model
// Assumes: Data line pulled up; 160 ns bit time
// Notes:   Clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module twr_host_model (
  input  wire logic line_i,  // Resolved data line
  output logic      scl_o,   // Serial clock
  output logic      sda_o    // Data drive, 1 releases
);
  localparam time Q = 40;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start();
    sda_o = 1'b1;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_o = 1'b0;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_o = 1'b1;
    #(2*Q);
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_o = b;
    #Q;
    scl_o = 1'b1;
    #Q;
    r = line_i;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nak, r);
  endtask
endmodule // twr_host_model
`default_nettype wire

// *** tb_two_wire_register_port.sv ***
// Purpose: Self-checking bench for the register port
// Assumes: Host model drives the bus
// Notes:   Register contents mirrored in mem
`timescale 1ns/1ps
`default_nettype none
module tb_two_wire_register_port import twr_pkg::*;;
  logic       clk, srst, sel, scl, msda, sda_o, oe_n, cb, mt, il, rv, pl, busy, sel_o, ack;
  logic [1:0] tv, cap, ph;
  logic [2:0] lu, ch;
  logic [7:0] d;
  logic [7:0] mem [26];
  int         ptr;
  int         fail_count = 0;
  int         check_count = 0;
  wire        line = msda & (oe_n | sda_o);
  twr_port dut (.core_clk_i(clk), .srst_i(srst), .serial_clock_line_i(scl),
    .serial_data_line_i(line), .serial_data_line_o(sda_o), .serial_data_line_oe_n_o(oe_n),
    .address_select_pin_i(sel), .tv_standard_o(tv), .luma_filter_o(lu), .chroma_filter_o(ch),
    .interlace_select_o(il), .caption_field_select_o(cap), .converter_powerdown_hi_o(ph),
    .converter_powerdown_lo_o(pl), .reserved_one_bit_o(rv), .color_bar_enable_o(cb),
    .master_timing_force_o(mt), .bus_busy_o(busy), .selected_o(sel_o));
  twr_host_model host (.line_i(line), .scl_o(scl), .sda_o(msda));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cfg();
    chk({ch, lu, tv}, mem[0]);
    chk({cb, ph, rv, pl, cap, il}, mem[1]);
    chk({7'h00, mt}, {7'h00, mem[1][7]});
  endtask
  function automatic logic [7:0] adr(input logic r);
    return {SLAVE_ADDR_HI[6:1], sel, r};
  endfunction
  task automatic hdr(input int p);
    host.start();
    host.wbyte(adr(1'b0), ack);
    chk(ack, 1);
    host.wbyte(p[7:0], ack);
    chk(ack, p < 26);
    ptr = p;
  endtask
  task automatic wr(input int p, input int n);
    hdr(p);
    for (int i = 0; i < n && ack; i++) begin
      d = 8'($urandom);
      if (ptr == 1) d[4] = 1'b1;
      host.wbyte(d, ack);
      chk(ack, ptr < 26);
      if (ptr < 26) mem[ptr] = d;
      ptr++;
    end
    host.stop();
    cfg();
  endtask
  task automatic rd(input int p, input int n);
    hdr(p);
    host.start();
    host.wbyte(adr(1'b1), ack);
    chk(ack, 1);
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1, d);
      chk(d, mem[ptr]);
      if (ptr < 25) ptr++;
    end
    host.stop();
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400us;
    fail_count++;
    end_of_test();
  end
  initial begin
    srst = 1'b1;
    sel = 1'b0;
    foreach (mem[i]) mem[i] = REG_RST;
    void'($urandom(53723));
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    cfg();
    chk(oe_n, 1);
    $display("test reset done");
    wr(0, 6);
    rd(0, 6);
    $display("test burst done");
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      repeat (4) @(posedge clk);
      host.start();
      host.wbyte(adr(1'b0) ^ 8'h02, ack);
      chk({ack, sel_o}, 0);
      host.stop();
      wr(1, 1);
      rd(1, 1);
    end
    $display("test address done");
    wr(26, 1);
    wr(8'h40, 1);
    $display("test bad pointer done");
    wr(24, 3);
    rd(24, 4);
    $display("test overflow done");
    for (int j = 0; j < 2; j++) begin
      hdr(j);
      repeat (4) host.bitx(1'b0, ack);
      if (j == 1) host.start();
      host.stop();
      cfg();
      chk(busy, 0);
    end
    $display("test abort done");
    end_of_test();
  end
endmodule // tb_two_wire_register_port
`default_nettype wire
